// ===== verilog/ulm_cfg.svh
// ulm_cfg.svh: numbers of the line and modem control block (offsets, fields, resets, counts).
// assumes it is included by bare name from the package and from every design file that needs it.
`ifndef ULM_CFG_SVH
`define ULM_CFG_SVH
// bus geometry
`define ULM_AW 12
`define ULM_IDX_RANGE 4:2
`define ULM_ADDR_HI 11:5
// register indexes, byte address is four times the index
`define ULM_IDX_DATA 3'h0
`define ULM_IDX_AUX 3'h1
`define ULM_IDX_LFC 3'h3
`define ULM_IDX_MLC 3'h4
`define ULM_IDX_STAT 3'h5
// line_format_control fields
`define ULM_LFC_LEN 1:0
`define ULM_LFC_STOP 2
`define ULM_LFC_PEN 3
`define ULM_LFC_PTYPE 5:4
`define ULM_LFC_BRK 6
`define ULM_LFC_BANK 7
// modem_line_control fields
`define ULM_MLC_DTR 0
`define ULM_MLC_RTS 1
`define ULM_MLC_AUXA 2
`define ULM_MLC_AUXB 3
`define ULM_MLC_LOOP 4
`define ULM_MLC_AFE 5
`define ULM_MLC_MASK 8'h3F
// reset values
`define ULM_LFC_RST 8'h00
`define ULM_MLC_RST 8'h00
`define ULM_DIV_RST 16'h0001
// parity codes
`define ULM_PAR_ODD 2'h0
`define ULM_PAR_EVEN 2'h1
`define ULM_PAR_MARK 2'h2
// oversampling: 16 ticks a bit
`define ULM_BIT_LAST 5'h0F
`define ULM_STOP15_LAST 5'h17
`define ULM_STOP2_LAST 5'h1F
`define ULM_RX_MID 4'h7
`define ULM_RX_LAST 4'hF
`define ULM_LEN_BASE 3'h4
// answers
`define ULM_RESP_OKAY 2'h0
`define ULM_RESP_SLVERR 2'h2
`endif

// ===== verilog/ulm_pkg.sv
// ulm_pkg: types shared by the line and modem control block and its serial engines.
// assumes ulm_cfg.svh sits on the include path.
package ulm_pkg;
	`include "ulm_cfg.svh"

	// bit phases of one serial character
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP} ulm_bit_e;

	// character format handed to the engines
	typedef struct packed {
		logic [1:0] len;
		logic stop;
		logic pen;
		logic [1:0] ptype;
		logic brk;
	} ulm_fmt_s;

	typedef struct packed {
		ulm_bit_e st;
		logic [4:0] cnt;
		logic [2:0] idx;
		logic [7:0] shift;
		logic line;
	} ulm_tx_s;

	typedef struct packed {
		ulm_bit_e st;
		logic [3:0] cnt;
		logic [2:0] idx;
		logic [7:0] data;
		logic valid;
	} ulm_rx_s;

	typedef struct packed {
		logic [7:0] lfc;
		logic [7:0] mlc;
		logic [15:0] div;
		logic [15:0] bcnt;
		logic tick;
		logic [7:0] thr;
		logic thr_full;
		logic tx_start;
		logic [7:0] rbr;
		logic rbr_ready;
		logic overrun;
		logic aw_got;
		logic [`ULM_AW-1:0] aw_addr;
		logic w_got;
		logic [7:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ulm_top_s;
endpackage : ulm_pkg

// ===== verilog/ulm_tx.sv
// ulm_tx: serial character transmitter with 16x oversampling ticks.
// assumes a one-cycle tick enable and a start pulse given only while idle.
`timescale 1ns/1ps
`include "ulm_cfg.svh"
module ulm_tx (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// control
	input wire logic i_tick,
	input wire logic i_start,
	input wire logic [7:0] i_data,
	input wire ulm_pkg::ulm_fmt_s i_fmt,
	// line and state
	output logic o_txd,
	output logic o_busy
);
	import ulm_pkg::*;
	ulm_tx_s s_q, s_d;
	logic [2:0] idx_last;
	logic [4:0] stop_last;
	logic [7:0] mask;
	logic par;

	// next state of the bit sequencer
	always_comb begin
		s_d = s_q;
		idx_last = `ULM_LEN_BASE + {1'b0, i_fmt.len};
		stop_last = !i_fmt.stop ? `ULM_BIT_LAST : (i_fmt.len == 2'h0) ? `ULM_STOP15_LAST : `ULM_STOP2_LAST;
		mask = 8'(8'hFF >> (2'h3 - i_fmt.len));
		case (i_fmt.ptype)
			`ULM_PAR_ODD: par = ~^(s_q.shift & mask);
			`ULM_PAR_EVEN: par = ^(s_q.shift & mask);
			`ULM_PAR_MARK: par = 1'b1;
			default: par = 1'b0;
		endcase
		case (s_q.st)
			ST_IDLE: begin
				if (i_start) begin
					s_d.shift = i_data;
					s_d.st = ST_START;
					s_d.cnt = 5'h00;
				end
			end
			ST_START, ST_DATA, ST_PARITY: begin
				if (i_tick) begin
					s_d.cnt = s_q.cnt + 5'h01;
					if (s_q.cnt == `ULM_BIT_LAST) begin
						s_d.cnt = 5'h00;
						if (s_q.st == ST_START) begin
							s_d.st = ST_DATA;
							s_d.idx = 3'h0;
						end else if (s_q.st == ST_DATA && s_q.idx != idx_last) begin
							s_d.idx = s_q.idx + 3'h1;
						end else if (s_q.st == ST_DATA && i_fmt.pen) begin
							s_d.st = ST_PARITY;
						end else begin
							s_d.st = ST_STOP;
						end
					end
				end
			end
			ST_STOP: begin
				if (i_tick) begin
					s_d.cnt = s_q.cnt + 5'h01;
					if (s_q.cnt == stop_last)
						s_d.st = ST_IDLE;
				end
			end
			default: s_d.st = ST_IDLE;
		endcase
		// line level follows the phase entered; break wins over all
		case (s_d.st)
			ST_START: s_d.line = 1'b0;
			ST_DATA: s_d.line = s_d.shift[s_d.idx];
			ST_PARITY: s_d.line = par;
			default: s_d.line = 1'b1;
		endcase
		if (i_fmt.brk)
			s_d.line = 1'b0;
	end

	// state register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			s_q <= '{st: ST_IDLE, cnt: 5'h00, idx: 3'h0, shift: 8'h00, line: 1'b1};
		else
			s_q <= s_d;
	end

	assign o_txd = s_q.line;
	assign o_busy = (s_q.st != ST_IDLE);
endmodule : ulm_tx

// ===== verilog/ulm_rx.sv
// ulm_rx: serial character receiver, samples mid-bit on 16x ticks, one stop bit checked.
// assumes the line input is already synchronous to the clock.
`timescale 1ns/1ps
`include "ulm_cfg.svh"
module ulm_rx (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// line
	input wire logic i_tick,
	input wire logic i_rxd,
	input wire ulm_pkg::ulm_fmt_s i_fmt,
	// character out
	output logic o_valid,
	output logic [7:0] o_data
);
	import ulm_pkg::*;
	ulm_rx_s s_q, s_d;

	// next state of the sampler
	always_comb begin
		s_d = s_q;
		s_d.valid = 1'b0;
		if (i_tick) begin
			s_d.cnt = s_q.cnt + 4'h1;
			case (s_q.st)
				ST_IDLE: begin
					s_d.cnt = 4'h0;
					if (!i_rxd) begin
						s_d.st = ST_START;
						s_d.data = 8'h00;
					end
				end
				ST_START: begin
					// glitch shorter than half a bit is dropped
					if (s_q.cnt == `ULM_RX_MID) begin
						s_d.cnt = 4'h0;
						s_d.idx = 3'h0;
						s_d.st = i_rxd ? ST_IDLE : ST_DATA;
					end
				end
				ST_DATA: begin
					if (s_q.cnt == `ULM_RX_LAST) begin
						s_d.data[s_q.idx] = i_rxd;
						s_d.idx = s_q.idx + 3'h1;
						if (s_q.idx == `ULM_LEN_BASE + {1'b0, i_fmt.len})
							s_d.st = i_fmt.pen ? ST_PARITY : ST_STOP;
					end
				end
				ST_PARITY: begin
					if (s_q.cnt == `ULM_RX_LAST)
						s_d.st = ST_STOP;
				end
				ST_STOP: begin
					if (s_q.cnt == `ULM_RX_LAST) begin
						s_d.st = ST_IDLE;
						s_d.valid = i_rxd;
					end
				end
				default: s_d.st = ST_IDLE;
			endcase
		end
	end

	// state register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			s_q <= '{st: ST_IDLE, cnt: 4'h0, idx: 3'h0, data: 8'h00, valid: 1'b0};
		else
			s_q <= s_d;
	end

	assign o_valid = s_q.valid;
	assign o_data = s_q.data;
endmodule : ulm_rx

// ===== verilog/ulm_top.sv
// ulm_top: line and modem control of one serial channel, registers on an AXI4-Lite slave.
// assumes one 100 MHz clock, synchronous pin inputs and an AXI4-Lite master with one
// write and one read under way at most.
`timescale 1ns/1ps
`include "ulm_cfg.svh"
module ulm_top (
	// clock and reset
	input wire logic I_CLOCK,
	input wire logic I_RST,
	// axi4-lite write address and data
	input wire logic I_AXI_AWVALID,
	output logic O_AXI_AWREADY,
	input wire logic [11:0] I_AXI_AWADDR,
	input wire logic I_AXI_WVALID,
	output logic O_AXI_WREADY,
	input wire logic [31:0] I_AXI_WDATA,
	input wire logic [3:0] I_AXI_WSTRB,
	// axi4-lite write response
	output logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	output logic [1:0] O_AXI_BRESP,
	// axi4-lite read
	input wire logic I_AXI_ARVALID,
	output logic O_AXI_ARREADY,
	input wire logic [11:0] I_AXI_ARADDR,
	output logic O_AXI_RVALID,
	input wire logic I_AXI_RREADY,
	output logic [31:0] O_AXI_RDATA,
	output logic [1:0] O_AXI_RRESP,
	// serial line
	output logic O_TXD,
	input wire logic I_RXD,
	// modem outputs, DTR and RTS active low at the pin, aux outputs active high
	output logic O_DTR_N,
	output logic O_RTS_N,
	output logic O_AUX_OUT_A,
	output logic O_AUX_OUT_B,
	// modem inputs, active low at the pin
	input wire logic I_CTS_N,
	input wire logic I_DSR_N,
	input wire logic I_RI_N,
	input wire logic I_DCD_N
);
	import ulm_pkg::*;

	ulm_top_s s_q, s_d;
	ulm_fmt_s fmt;
	logic tx_txd;
	logic tx_busy;
	logic rx_valid;
	logic [7:0] rx_data;
	logic loop_on;
	logic afe_on;
	logic auto_rts;
	logic cts_eff;
	logic dsr_eff;
	logic ri_eff;
	logic dcd_eff;
	logic rxd_src;
	logic [7:0] len_mask;
	logic [7:0] stat;

	// decoded mode bits
	assign loop_on = s_q.mlc[`ULM_MLC_LOOP];
	assign afe_on = s_q.mlc[`ULM_MLC_AFE];
	assign auto_rts = afe_on && s_q.mlc[`ULM_MLC_RTS];

	// character format from line_format_control
	assign fmt.len = s_q.lfc[`ULM_LFC_LEN];
	assign fmt.stop = s_q.lfc[`ULM_LFC_STOP];
	assign fmt.pen = s_q.lfc[`ULM_LFC_PEN];
	assign fmt.ptype = s_q.lfc[`ULM_LFC_PTYPE];
	assign fmt.brk = s_q.lfc[`ULM_LFC_BRK];
	assign len_mask = 8'(8'hFF >> (2'h3 - fmt.len));

	// modem input paths; loopback turns the outputs back in
	assign cts_eff = loop_on ? s_q.mlc[`ULM_MLC_RTS] : !I_CTS_N;
	assign dsr_eff = loop_on ? s_q.mlc[`ULM_MLC_DTR] : !I_DSR_N;
	assign ri_eff = loop_on ? s_q.mlc[`ULM_MLC_AUXA] : !I_RI_N;
	assign dcd_eff = loop_on ? s_q.mlc[`ULM_MLC_AUXB] : !I_DCD_N;
	// in loopback the receiver hears our own line, the pin idles at mark
	assign rxd_src = loop_on ? tx_txd : I_RXD;

	// status word: modem inputs over the block's own state
	assign stat = {dcd_eff, ri_eff, dsr_eff, cts_eff, tx_busy, s_q.thr_full, s_q.overrun, s_q.rbr_ready};

	// serial engines
	ulm_tx u_tx (
		.i_clk(I_CLOCK),
		.i_rst(I_RST),
		.i_tick(s_q.tick),
		.i_start(s_q.tx_start),
		.i_data(s_q.thr),
		.i_fmt(fmt),
		.o_txd(tx_txd),
		.o_busy(tx_busy)
	);

	ulm_rx u_rx (
		.i_clk(I_CLOCK),
		.i_rst(I_RST),
		.i_tick(s_q.tick),
		.i_rxd(rxd_src),
		.i_fmt(fmt),
		.o_valid(rx_valid),
		.o_data(rx_data)
	);

	// next state of registers, flow control and bus slave
	always_comb begin
		s_d = s_q;

		// baud divider: one tick every div cycles, a zero divisor acts as one
		s_d.tick = 1'b0;
		if (s_q.bcnt + 16'h0001 >= s_q.div) begin
			s_d.bcnt = 16'h0000;
			s_d.tick = 1'b1;
		end else begin
			s_d.bcnt = s_q.bcnt + 16'h0001;
		end

		// hand the held character to the transmitter; auto-CTS waits for clear
		s_d.tx_start = 1'b0;
		if (s_q.thr_full && !tx_busy && !s_q.tx_start && (!afe_on || cts_eff)) begin
			s_d.tx_start = 1'b1;
			s_d.thr_full = 1'b0;
		end

		// receive side: with AFE clear the line is bypassed entirely
		if (!afe_on) begin
			if (s_d.tx_start) begin
				s_d.rbr = s_q.thr & len_mask;
				s_d.overrun = s_q.overrun || s_q.rbr_ready;
				s_d.rbr_ready = 1'b1;
			end
		end else if (rx_valid) begin
			s_d.rbr = rx_data;
			s_d.overrun = s_q.overrun || s_q.rbr_ready;
			s_d.rbr_ready = 1'b1;
		end

		// write address and data are taken in either order
		if (I_AXI_AWVALID && O_AXI_AWREADY) begin
			s_d.aw_got = 1'b1;
			s_d.aw_addr = I_AXI_AWADDR;
		end
		if (I_AXI_WVALID && O_AXI_WREADY) begin
			s_d.w_got = 1'b1;
			s_d.wdata = I_AXI_WDATA[7:0];
			s_d.wstrb0 = I_AXI_WSTRB[0];
		end

		// perform the write once both halves are in
		if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = `ULM_RESP_OKAY;
			if (s_q.aw_addr[`ULM_ADDR_HI] != 7'h00) begin
				s_d.bresp = `ULM_RESP_SLVERR;
			end else begin
				case (s_q.aw_addr[`ULM_IDX_RANGE])
					`ULM_IDX_DATA: begin
						if (s_q.wstrb0) begin
							if (s_q.lfc[`ULM_LFC_BANK]) begin
								s_d.div[7:0] = s_q.wdata;
							end else if (!s_d.thr_full) begin
								// a character written while one waits is lost
								s_d.thr = s_q.wdata;
								s_d.thr_full = 1'b1;
							end
						end
					end
					`ULM_IDX_AUX: begin
						if (s_q.wstrb0 && s_q.lfc[`ULM_LFC_BANK])
							s_d.div[15:8] = s_q.wdata;
					end
					`ULM_IDX_LFC: begin
						if (s_q.wstrb0)
							s_d.lfc = s_q.wdata;
					end
					`ULM_IDX_MLC: begin
						if (s_q.wstrb0)
							s_d.mlc = s_q.wdata & `ULM_MLC_MASK;
					end
					`ULM_IDX_STAT: begin
						// read-only, the write is accepted and dropped
					end
					default: s_d.bresp = `ULM_RESP_SLVERR;
				endcase
			end
		end
		if (s_q.bvalid && I_AXI_BREADY)
			s_d.bvalid = 1'b0;

		// read: answer one cycle after the address is taken
		if (I_AXI_ARVALID && O_AXI_ARREADY) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = `ULM_RESP_OKAY;
			s_d.rdata = 32'h0000_0000;
			if (I_AXI_ARADDR[`ULM_ADDR_HI] != 7'h00) begin
				s_d.rresp = `ULM_RESP_SLVERR;
			end else begin
				case (I_AXI_ARADDR[`ULM_IDX_RANGE])
					`ULM_IDX_DATA: begin
						if (s_q.lfc[`ULM_LFC_BANK]) begin
							s_d.rdata[7:0] = s_q.div[7:0];
						end else begin
							s_d.rdata[7:0] = s_q.rbr;
							// a character arriving now keeps ready set
							if (!(rx_valid && afe_on) && !(s_d.tx_start && !afe_on))
								s_d.rbr_ready = 1'b0;
						end
					end
					`ULM_IDX_AUX: begin
						if (s_q.lfc[`ULM_LFC_BANK])
							s_d.rdata[7:0] = s_q.div[15:8];
					end
					`ULM_IDX_LFC: s_d.rdata[7:0] = s_q.lfc;
					`ULM_IDX_MLC: s_d.rdata[7:0] = s_q.mlc;
					`ULM_IDX_STAT: begin
						s_d.rdata[7:0] = stat;
						// overrun clears on read unless a new one lands this cycle
						if (!(s_d.overrun && !s_q.overrun) && !(s_q.overrun && s_q.rbr_ready &&
							((rx_valid && afe_on) || (s_d.tx_start && !afe_on))))
							s_d.overrun = 1'b0;
					end
					default: s_d.rresp = `ULM_RESP_SLVERR;
				endcase
			end
		end
		if (s_q.rvalid && I_AXI_RREADY)
			s_d.rvalid = 1'b0;
	end

	// single state register of the block
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			s_q <= '0;
			s_q.lfc <= `ULM_LFC_RST;
			s_q.mlc <= `ULM_MLC_RST;
			s_q.div <= `ULM_DIV_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// bus handshake: one write and one read in flight at most
	assign O_AXI_AWREADY = !s_q.aw_got && !s_q.bvalid;
	assign O_AXI_WREADY = !s_q.w_got && !s_q.bvalid;
	assign O_AXI_BVALID = s_q.bvalid;
	assign O_AXI_BRESP = s_q.bresp;
	assign O_AXI_ARREADY = !s_q.rvalid;
	assign O_AXI_RVALID = s_q.rvalid;
	assign O_AXI_RDATA = s_q.rdata;
	assign O_AXI_RRESP = s_q.rresp;

	// modem and line pins
	assign O_TXD = loop_on ? 1'b1 : tx_txd;
	// a set control bit pulls its pin low, a clear bit leaves it high
	assign O_DTR_N = !s_q.mlc[`ULM_MLC_DTR];
	// auto-RTS asks for data only while the receive holding register is free
	assign O_RTS_N = auto_rts ? s_q.rbr_ready : !s_q.mlc[`ULM_MLC_RTS];
	assign O_AUX_OUT_A = s_q.mlc[`ULM_MLC_AUXA];
	assign O_AUX_OUT_B = s_q.mlc[`ULM_MLC_AUXB];
endmodule : ulm_top

// ===== tb/ulm_top_checker.sv
// ulm_top_checker: port-level assertions for ulm_top, bound into every instance.
// assumes writes offer address and data in the same cycle, as the bench does.
`timescale 1ns/1ps
module ulm_top_checker (
	// clock and reset
	input wire logic I_CLOCK,
	input wire logic I_RST,
	// axi4-lite
	input wire logic I_AXI_AWVALID,
	input wire logic O_AXI_AWREADY,
	input wire logic [11:0] I_AXI_AWADDR,
	input wire logic I_AXI_WVALID,
	input wire logic O_AXI_WREADY,
	input wire logic [31:0] I_AXI_WDATA,
	input wire logic [3:0] I_AXI_WSTRB,
	input wire logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	input wire logic [1:0] O_AXI_BRESP,
	input wire logic I_AXI_ARVALID,
	input wire logic O_AXI_ARREADY,
	input wire logic O_AXI_RVALID,
	input wire logic I_AXI_RREADY,
	input wire logic [31:0] O_AXI_RDATA,
	// pins
	input wire logic O_TXD,
	input wire logic O_DTR_N,
	input wire logic O_RTS_N,
	input wire logic O_AUX_OUT_A,
	input wire logic O_AUX_OUT_B
);
	logic hs, bad_d, pend_q, stb_q, bad_q;
	logic [2:0] idx_q;
	logic [7:0] dat_q, lfc_q, mlc_q;
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (I_RST);
	// both channels taken in one cycle, as the bench offers them
	assign hs = I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID && O_AXI_WREADY;
	assign bad_d = I_AXI_AWADDR[11:5] != 7'h00 || I_AXI_AWADDR[4:2] inside {3'h2, 3'h6, 3'h7};
	// shadow of both control registers, updated on the design's perform edge
	always_ff @(posedge I_CLOCK or posedge I_RST) begin
		if (I_RST) begin
			pend_q <= 1'b0;
			stb_q <= 1'b0;
			bad_q <= 1'b0;
			idx_q <= 3'h0;
			dat_q <= 8'h00;
			lfc_q <= 8'h00;
			mlc_q <= 8'h00;
		end else begin
			pend_q <= hs;
			if (hs) begin
				stb_q <= I_AXI_WSTRB[0];
				bad_q <= bad_d;
				idx_q <= I_AXI_AWADDR[4:2];
				dat_q <= I_AXI_WDATA[7:0];
			end
			if (pend_q && stb_q && !bad_q && idx_q == 3'h3) lfc_q <= dat_q;
			if (pend_q && stb_q && !bad_q && idx_q == 3'h4) mlc_q <= dat_q & 8'h3F;
		end
	end
	sequence wr_taken;
		hs;
	endsequence
	sequence brk_on;
		lfc_q[6] && !mlc_q[4] ##1 lfc_q[6] && !mlc_q[4];
	endsequence
	sequence loop_on;
		mlc_q[4] ##1 mlc_q[4];
	endsequence
	a_write_resp: assert property (wr_taken |-> ##2 O_AXI_BVALID && O_AXI_BRESP == {bad_q, 1'b0})
		else $error("write answer late or wrong");
	a_bvalid_hold: assert property (O_AXI_BVALID && !I_AXI_BREADY |=> O_AXI_BVALID && $stable(O_AXI_BRESP))
		else $error("write answer dropped early");
	a_read_answer: assert property (I_AXI_ARVALID && O_AXI_ARREADY |=> O_AXI_RVALID && O_AXI_RDATA[31:8] == 24'h0)
		else $error("read answer late or wide");
	a_rvalid_hold: assert property (O_AXI_RVALID && !I_AXI_RREADY |=> O_AXI_RVALID && $stable(O_AXI_RDATA))
		else $error("read answer dropped early");
	a_dtr_level: assert property (O_DTR_N == !mlc_q[0])
		else $error("dtr pin off its control bit");
	a_rts_manual: assert property (!(mlc_q[5] && mlc_q[1]) |-> O_RTS_N == !mlc_q[1])
		else $error("rts pin off its control bit");
	a_aux_pins: assert property ({O_AUX_OUT_B, O_AUX_OUT_A} == mlc_q[3:2])
		else $error("aux pins off their bits");
	a_break_space: assert property (brk_on |-> !O_TXD)
		else $error("break not holding space");
	a_loop_mark: assert property (loop_on |-> O_TXD)
		else $error("line not at mark in loopback");
endmodule : ulm_top_checker

bind ulm_top ulm_top_checker u_ulm_top_checker (.*);

// ===== tb/ulm_remote.sv
// ulm_remote: far-end serial device, decodes frames on txd and sends frames on rxd.
// assumes a divisor of 1, so one bit lasts 16 clocks.
`timescale 1ns/1ps
module ulm_remote (
	// clock and line in
	input wire logic i_clk,
	input wire logic i_txd,
	// expected format
	input wire logic [3:0] i_bits,
	input wire logic i_pen,
	// lines out
	output logic o_rxd,
	output logic o_cts_n
);
	logic stall = 1'b0;
	logic [7:0] data;
	logic par, stp;
	int nfr = 0, nst = 0, gap = 0, t0 = 0, cyc = 0;
	// cts is a plain level, withdrawn while stalled
	assign o_cts_n = stall;
	initial o_rxd = 1'b1;
	always @(posedge i_clk) cyc <= cyc + 1;
	// samples mid-bit, rearms after the first stop middle so gaps stay exact
	initial begin
		forever begin
			@(posedge i_clk);
			if (i_txd === 1'b0) begin
				gap = cyc - t0;
				t0 = cyc;
				nst++;
				data = 8'h00;
				repeat (8) @(posedge i_clk);
				for (int i = 0; i < i_bits; i++) begin
					repeat (16) @(posedge i_clk);
					data[i] = i_txd;
				end
				if (i_pen) begin
					repeat (16) @(posedge i_clk);
					par = i_txd;
				end
				repeat (16) @(posedge i_clk);
				stp = i_txd;
				nfr++;
			end
		end
	end
	// one 8N1 character, line back at mark afterwards
	task automatic send(input logic [7:0] d);
		o_rxd <= 1'b0;
		repeat (16) @(posedge i_clk);
		for (int i = 0; i < 8; i++) begin
			o_rxd <= d[i];
			repeat (16) @(posedge i_clk);
		end
		o_rxd <= 1'b1;
		repeat (16) @(posedge i_clk);
	endtask : send
endmodule : ulm_remote

// ===== tb/tb_uart_line_modem_control.sv
// tb_uart_line_modem_control: self-checking bench for ulm_top with a remote serial device.
// assumes the divisor is 1 outside the bank test and the other modem inputs stay asserted.
`timescale 1ns/1ps
module tb_uart_line_modem_control;
	typedef struct {logic [11:0] a; logic [7:0] w; logic [7:0] r; logic [1:0] resp; logic [3:0] pins;} ulm_row_s;
	logic clk, rst, awv, wv, bry, arv, rry, rxd, cts_n, awr, wrd, bv, arr, rv, txd, dtr_n, rts_n, auxa, auxb, pen, ep;
	logic [11:0] awa, ara;
	logic [31:0] wd, rdat;
	logic [3:0] ws, nbits;
	logic [1:0] bresp, rresp;
	logic [7:0] f, ed;
	int errors = 0, checked = 0, cyc = 0, nb, fl, n;
	logic [7:0] fmts[6] = '{8'h00, 8'h04, 8'h0F, 8'h1A, 8'h2D, 8'h3B};
	ulm_row_s rows[8] = '{'{12'h010, 8'h01, 8'h01, 2'h0, 4'h2}, '{12'h010, 8'h02, 8'h02, 2'h0, 4'h1},
		'{12'h010, 8'h0C, 8'h0C, 2'h0, 4'hF}, '{12'h010, 8'hFF, 8'h3F, 2'h0, 4'hC},
		'{12'h010, 8'h00, 8'h00, 2'h0, 4'h3}, '{12'h00C, 8'h3F, 8'h3F, 2'h0, 4'h3},
		'{12'h00C, 8'h00, 8'h00, 2'h0, 4'h3}, '{12'h018, 8'h55, 8'h00, 2'h2, 4'h3}};
	ulm_top u_ulm_top (.I_CLOCK(clk), .I_RST(rst), .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr), .I_AXI_AWADDR(awa),
		.I_AXI_WVALID(wv), .O_AXI_WREADY(wrd), .I_AXI_WDATA(wd), .I_AXI_WSTRB(ws), .O_AXI_BVALID(bv),
		.I_AXI_BREADY(bry), .O_AXI_BRESP(bresp), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr), .I_AXI_ARADDR(ara),
		.O_AXI_RVALID(rv), .I_AXI_RREADY(rry), .O_AXI_RDATA(rdat), .O_AXI_RRESP(rresp), .O_TXD(txd), .I_RXD(rxd),
		.O_DTR_N(dtr_n), .O_RTS_N(rts_n), .O_AUX_OUT_A(auxa), .O_AUX_OUT_B(auxb), .I_CTS_N(cts_n),
		.I_DSR_N(1'b0), .I_RI_N(1'b0), .I_DCD_N(1'b0));
	ulm_remote u_ulm_remote (.i_clk(clk), .i_txd(txd), .i_bits(nbits), .i_pen(pen), .o_rxd(rxd), .o_cts_n(cts_n));
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// write with both channels offered together, bready held until the answer
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		@(posedge clk);
		awa <= a;
		wd <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		bry <= 1'b1;
		do begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrd) wv <= 1'b0;
		end while (bv !== 1'b1);
		chk("bresp", er, bresp);
		bry <= 1'b0;
	endtask : wr
	// read; data compared under a mask only when the expected answer is OKAY
	task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		do begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
		end while (rv !== 1'b1);
		chk("rresp", er, rresp);
		if (er == 2'h0) chk("rdata", e, rdat & m);
		rry <= 1'b0;
	endtask : rd
	// bounded wait on the remote's start or frame count
	task automatic wait_cnt(input logic s, input int c);
		for (int k = 0; k < 4000; k++) begin
			if ((s ? u_ulm_remote.nst : u_ulm_remote.nfr) >= c) break;
			@(posedge clk);
		end
	endtask : wait_cnt
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard, several times the expected run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			close_out();
		end
	end
	initial begin
		{rst, awv, wv, bry, arv, rry, pen} = 7'h40;
		{awa, ara, wd, ws, nbits} = {24'h0, 32'h0, 4'hF, 4'h8};
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk("pins", 32'h07, {auxb, auxa, rts_n, dtr_n, txd});
		rd(12'h00C, 32'hFF, 32'h0, 2'h0);
		rd(12'h010, 32'hFF, 32'h0, 2'h0);
		$display("reset test done");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w, rows[i].resp);
			rd(rows[i].a, 32'hFF, {24'h0, rows[i].r}, rows[i].resp);
			chk("pins", {28'h0, rows[i].pins}, {28'h0, auxb, auxa, rts_n, dtr_n});
		end
		$display("row tests done");
		wr(12'h00C, 8'h80, 2'h0);
		wr(12'h000, 8'h02, 2'h0);
		rd(12'h000, 32'hFF, 32'h2, 2'h0);
		wr(12'h004, 8'h01, 2'h0);
		rd(12'h004, 32'hFF, 32'h1, 2'h0);
		wr(12'h004, 8'h00, 2'h0);
		wr(12'h000, 8'h01, 2'h0);
		$display("bank test done");
		wr(12'h010, 8'h20, 2'h0);
		// two back-to-back characters per format; the start gap gives the stop length
		foreach (fmts[i]) begin
			f = fmts[i];
			nb = 5 + f[1:0];
			nbits <= nb[3:0];
			pen <= f[3];
			wr(12'h00C, f, 2'h0);
			n = u_ulm_remote.nfr;
			wr(12'h000, 8'hA5, 2'h0);
			wait_cnt(1'b1, u_ulm_remote.nst + 1);
			wr(12'h000, 8'hA5, 2'h0);
			wait_cnt(1'b0, n + 2);
			ed = 8'hA5 & ~(8'hFF << nb);
			ep = f[5] ? ~f[4] : (^ed ^ ~f[4]); // odd, even, mark, space
			fl = 16 * (1 + nb + f[3]) + (!f[2] ? 16 : (f[1:0] == 2'h0 ? 24 : 32));
			chk("data", ed, u_ulm_remote.data);
			if (f[3]) chk("parity", ep, u_ulm_remote.par);
			chk("stop", 32'h1, u_ulm_remote.stp);
			chk("gap", 32'h1, u_ulm_remote.gap >= fl && u_ulm_remote.gap <= fl + 4);
		end
		$display("format tests done");
		u_ulm_remote.stall <= 1'b1;
		n = u_ulm_remote.nfr;
		wr(12'h000, 8'h11, 2'h0);
		repeat (200) @(posedge clk);
		chk("held frames", n, u_ulm_remote.nfr);
		u_ulm_remote.stall <= 1'b0;
		wait_cnt(1'b0, n + 1);
		chk("data", 32'h11, u_ulm_remote.data);
		// the remote sends 8N1, so the receiver must not expect a parity slot
		wr(12'h00C, 8'h03, 2'h0);
		pen <= 1'b0;
		wr(12'h010, 8'h22, 2'h0);
		u_ulm_remote.send(8'h3C);
		chk("rts full", 32'h1, rts_n);
		rd(12'h000, 32'hFF, 32'h3C, 2'h0);
		chk("rts empty", 32'h0, rts_n);
		$display("flow tests done");
		wr(12'h010, 8'h00, 2'h0);
		n = u_ulm_remote.nfr;
		wr(12'h000, 8'h5A, 2'h0);
		repeat (6) @(posedge clk);
		rd(12'h014, 32'h1, 32'h1, 2'h0);
		rd(12'h000, 32'hFF, 32'h5A, 2'h0);
		wait_cnt(1'b0, n + 1);
		rd(12'h014, 32'hF0, 32'hF0, 2'h0);
		wr(12'h010, 8'h14, 2'h0);
		rd(12'h014, 32'hF0, 32'h40, 2'h0);
		wr(12'h010, 8'h18, 2'h0);
		rd(12'h014, 32'hF0, 32'h80, 2'h0);
		chk("txd", 32'h1, txd);
		$display("loopback tests done");
		wr(12'h010, 8'h20, 2'h0);
		wr(12'h00C, 8'h43, 2'h0);
		repeat (40) @(posedge clk);
		chk("txd", 32'h0, txd);
		wr(12'h00C, 8'h03, 2'h0);
		repeat (4) @(posedge clk);
		chk("txd", 32'h1, txd);
		$display("break test done");
		close_out();
	end
endmodule : tb_uart_line_modem_control
